// [hw/motor_fault_ctrl.sv]
// fault supervision and power mode control of a stepper driver
// assumes analog comparators arrive as asynchronous level flags and an
// avalon-mm master on ref_clk reaches the status and control words
`timescale 1ns/10ps
module motor_fault_ctrl #(
    parameter int SLEEP_CYC = fault_pkg::SLEEP_ENTRY_CYC,
    parameter int RETRY_CYC = fault_pkg::RETRY_WAIT_CYC,
    parameter int OL_CYC    = fault_pkg::OL_DETECT_CYC,
    parameter int WAKE_CYCS = fault_pkg::WAKE_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        sleep_in_low_active,
    input  wire logic        enable_pin_high,
    input  wire logic        enable_pin_float,
    input  wire logic        supply_lockout,
    input  wire logic        pump_rail_undervoltage,
    input  wire logic [7:0]  fet_current_limit,
    input  wire logic [1:0]  coil_below_threshold,
    input  wire logic        thermal_shutdown,
    output logic             fault_out_low_active,
    output logic             fault_out_low_active_oe,
    output logic             bridge_enable,
    output logic             pump_enable,
    output logic             regulator_enable,
    output logic             indexer_enable,
    output logic             inputs_ready,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest
);
    import fault_pkg::*;

    typedef struct packed {
        mode_e       mode;
        logic        sleep_prev;
        logic [31:0] low_cnt;
        logic [31:0] wake_cnt;
        logic [31:0] retry_cnt;
        logic        overcurrent_protect;
        logic        ol;
        logic        ot;
        logic        inhibit;
        logic        ack;
        logic [31:0] rdata;
        logic        bridge_en;
        logic        pump_en;
        logic        reg_en;
        logic        logic_en;
        logic        fault;
        logic        ready;
    } ctrl_s;

    ctrl_s st_q;
    ctrl_s st_d;

    logic [13:0] pins_s;
    logic        sleep_s;
    logic        en_high_s;
    logic        en_float_s;
    logic        lockout_s;
    logic        pump_rail_undervoltage_s;
    logic        ilim_s;
    logic        coil_low_s;
    logic        hot_s;
    logic        ocp_hit;
    logic        ol_hit;
    logic        ol_cond;

    sync2 #(
        .W (14)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({sleep_in_low_active, enable_pin_high, enable_pin_float, supply_lockout,
                    pump_rail_undervoltage, fet_current_limit, thermal_shutdown}),
        .sync_out (pins_s[13:0])
    );

    logic [1:0] coil_s;

    sync2 #(
        .W (2)
    ) u_sync_coil (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (coil_below_threshold),
        .sync_out (coil_s)
    );

    assign sleep_s    = pins_s[13];
    assign en_high_s  = pins_s[12];
    assign en_float_s = pins_s[11];
    assign lockout_s  = pins_s[10];
    assign pump_rail_undervoltage_s     = pins_s[9];
    assign ilim_s     = |pins_s[8:1];
    assign hot_s      = pins_s[0];
    assign coil_low_s = |coil_s;

    persist_timer #(
        .CYC (OCP_FILTER_CYC)
    ) u_ocp_filter (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cond    (ilim_s),
        .hit     (ocp_hit)
    );

    // open load only judged while coils are driven
    assign ol_cond = coil_low_s && st_q.bridge_en;

    persist_timer #(
        .CYC (OL_CYC)
    ) u_ol_filter (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cond    (ol_cond),
        .hit     (ol_hit)
    );

    logic en_latched;
    logic en_low;
    logic sleep_rise;
    logic reset_pulse;
    logic power_clear;
    logic req;

    always_comb begin
        en_latched  = en_float_s;
        en_low      = !en_float_s && !en_high_s;
        sleep_rise  = sleep_s && !st_q.sleep_prev;
        // low time over the minimum clears, longer short ones too
        reset_pulse = sleep_rise && (st_q.mode != MODE_SLEEP)
                      && (st_q.low_cnt > 32'(PULSE_MIN_CYC));
        // sleep or lockout behaves as a power cycle for every flag except thermal, which clears only once cool
        power_clear = (st_q.mode == MODE_SLEEP) || lockout_s;
        req         = read || write;

        st_d            = st_q;
        st_d.sleep_prev = sleep_s;

        if (sleep_s) begin
            st_d.low_cnt = '0;
        end else if (st_q.low_cnt < 32'(SLEEP_CYC)) begin
            st_d.low_cnt = st_q.low_cnt + 32'h1;
        end

        unique case (st_q.mode)
            MODE_SLEEP: begin
                // leave sleep on rising sleep pin
                if (sleep_s) begin
                    st_d.mode     = MODE_WAKE;
                    st_d.wake_cnt = '0;
                end
            end
            MODE_WAKE: begin
                if (st_q.wake_cnt < 32'(WAKE_CYCS)) begin
                    st_d.wake_cnt = st_q.wake_cnt + 32'h1;
                end else begin
                    st_d.mode = MODE_RUN;
                end
            end
            MODE_RUN: begin
            end
        endcase
        // entry after the sleep entry time of low pin
        if (!sleep_s && st_q.low_cnt >= 32'(SLEEP_CYC)) begin
            st_d.mode = MODE_SLEEP;
        end else if (lockout_s && st_q.mode != MODE_SLEEP) begin
            // logic held in reset, wake sequence again on return
            st_d.mode     = MODE_WAKE;
            st_d.wake_cnt = '0;
        end

        // retry wait runs from the overcurrent event
        if (!st_q.overcurrent_protect) begin
            st_d.retry_cnt = '0;
        end else if (st_q.retry_cnt < 32'(RETRY_CYC)) begin
            st_d.retry_cnt = st_q.retry_cnt + 32'h1;
        end

        // mode read live each cycle; latched holds until pulse
        if (power_clear || reset_pulse
            || (!en_latched && st_q.retry_cnt >= 32'(RETRY_CYC) && !ilim_s)) begin
            st_d.overcurrent_protect = 1'b0;
        end
        // pulse only clears flags; a new event still wins
        if (ocp_hit && !power_clear) begin
            st_d.overcurrent_protect = 1'b1;
        end

        if (power_clear || (en_latched ? reset_pulse : !ol_hit)) begin
            st_d.ol = 1'b0;
        end
        if (ol_hit && !power_clear) begin
            st_d.ol = 1'b1;
        end

        // latched thermal needs cooling and a pulse, retry needs cooling
        if (!hot_s && (power_clear || !en_latched || reset_pulse)) begin
            st_d.ot = 1'b0;
        end
        if (hot_s && !lockout_s) begin
            st_d.ot = 1'b1;
        end

        // bridges only in run, enable not low, not inhibited, no fault other than open load
        st_d.bridge_en = (st_d.mode == MODE_RUN) && !en_low && !st_q.inhibit && !pump_rail_undervoltage_s
                         && !lockout_s && !st_d.overcurrent_protect && !st_d.ot;
        // pump stays up on rail fault, dropped on heat or lockout
        st_d.pump_en   = (st_d.mode != MODE_SLEEP) && !lockout_s && !st_d.ot;
        st_d.reg_en    = (st_d.mode != MODE_SLEEP);
        st_d.logic_en  = (st_d.mode != MODE_SLEEP) && !lockout_s;
        st_d.ready     = (st_d.mode == MODE_RUN) && !lockout_s;
        // any live or latched fault holds the line low
        st_d.fault     = lockout_s || pump_rail_undervoltage_s || st_d.overcurrent_protect || st_d.ol || st_d.ot;

        // one wait state per access; write lands on the answering edge
        st_d.ack = req && !st_q.ack;
        if (req && !st_q.ack) begin
            st_d.rdata = '0;
            if (read && address == STATUS_OFS) begin
                st_d.rdata[ST_OCP]          = st_q.overcurrent_protect;
                st_d.rdata[ST_OL]           = st_q.ol;
                st_d.rdata[ST_OT]           = st_q.ot;
                st_d.rdata[ST_PUMP_RAIL_UNDERVOLTAGE]         = pump_rail_undervoltage_s;
                st_d.rdata[ST_LOCK]         = lockout_s;
                st_d.rdata[ST_FAULT]        = st_q.fault;
                st_d.rdata[ST_BRIDGE]       = st_q.bridge_en;
                st_d.rdata[ST_PUMP]         = st_q.pump_en;
                st_d.rdata[ST_MODE+1:ST_MODE] = st_q.mode;
                st_d.rdata[ST_READY]        = st_q.ready;
                st_d.rdata[ST_LATCHED]      = en_latched;
            end else if (read && address == CTRL_OFS) begin
                st_d.rdata[CTRL_INHIBIT] = st_q.inhibit;
            end
        end
        if (write && st_q.ack && address == CTRL_OFS) begin
            st_d.inhibit = writedata[CTRL_INHIBIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q         <= '0;
            st_q.mode    <= MODE_WAKE;
            st_q.inhibit <= CTRL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // open drain: only ever pulls low
    assign fault_out_low_active    = 1'b0;
    assign fault_out_low_active_oe = st_q.fault;
    assign bridge_enable           = st_q.bridge_en;
    assign pump_enable             = st_q.pump_en;
    assign regulator_enable        = st_q.reg_en;
    assign indexer_enable          = st_q.logic_en;
    assign inputs_ready            = st_q.ready;
    assign readdata                = st_q.rdata;
    assign waitrequest             = req && !st_q.ack;
endmodule

// [hw/fault_pkg.sv]
// constants, types and status layout for the motor driver fault and mode block
// assumes a single 100 MHz ref_clk; pin inputs arrive unsynchronised
package fault_pkg;
    localparam int CLK_PERIOD_NS = 10;

    // time figures in their own units
    localparam int PULSE_MIN_US        = 20;
    localparam int SLEEP_ENTRY_US      = 120;
    localparam int OCP_FILTER_NS       = 2000;
    localparam int RETRY_WAIT_US       = 4000;
    localparam int OPEN_LOAD_DETECT_US = 200;
    localparam int WAKE_US             = 1000;

    // least times round up
    localparam int PULSE_MIN_CYC   = (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OCP_FILTER_CYC  = (OCP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RETRY_WAIT_CYC  = (RETRY_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OL_DETECT_CYC   = (OPEN_LOAD_DETECT_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int WAKE_CYC        = (WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register map, byte addresses
    localparam logic [3:0] STATUS_OFS = 4'h0;
    localparam logic [3:0] CTRL_OFS   = 4'h4;
    localparam logic       CTRL_RST   = 1'h0;

    // status bit positions
    localparam int ST_OCP     = 0;
    localparam int ST_OL      = 1;
    localparam int ST_OT      = 2;
    localparam int ST_PUMP_RAIL_UNDERVOLTAGE    = 3;
    localparam int ST_LOCK    = 4;
    localparam int ST_FAULT   = 5;
    localparam int ST_BRIDGE  = 6;
    localparam int ST_PUMP    = 7;
    localparam int ST_MODE    = 8;
    localparam int ST_READY   = 10;
    localparam int ST_LATCHED = 11;
    localparam int CTRL_INHIBIT = 0;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_WAKE,
        MODE_RUN
    } mode_e;
endpackage

// [hw/sync2.sv]
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no bit-to-bit coherence is promised
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    always_comb begin
        st_d        = st_q;
        st_d.meta   = async_in;
        // first stage feeds only the second
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;
endmodule

// [hw/persist_timer.sv]
// flags a condition that has held for more than a fixed number of cycles
// assumes cond is already synchronised to ref_clk
`timescale 1ns/10ps
module persist_timer #(
    parameter int CYC = 1
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic cond,
    output logic      hit
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        hit;
    } tmr_s;

    tmr_s st_q;
    tmr_s st_d;

    always_comb begin
        st_d = st_q;
        if (!cond) begin
            st_d.cnt = '0;
        end else if (st_q.cnt < 32'(CYC)) begin
            st_d.cnt = st_q.cnt + 32'h1;
        end
        // saturating count keeps hit steady on long faults
        st_d.hit = cond && (st_q.cnt >= 32'(CYC));
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hit = st_q.hit;
endmodule

// [dv/motor_fault_ctrl_properties.sv]
// pin level assertions for the motor driver fault and mode block
// assumes one ref_clk domain and the short sleep and wake counts of the bench
`timescale 1ns/10ps
module motor_fault_ctrl_properties
    import fault_pkg::*;
#(
    parameter int SLEEP_CYC = 12000
) (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       sleep_in_low_active,
    input wire logic       enable_pin_high,
    input wire logic       enable_pin_float,
    input wire logic       supply_lockout,
    input wire logic       pump_rail_undervoltage,
    input wire logic [7:0] fet_current_limit,
    input wire logic       thermal_shutdown,
    input wire logic       fault_out_low_active,
    input wire logic       fault_out_low_active_oe,
    input wire logic       bridge_enable,
    input wire logic       pump_enable,
    input wire logic       regulator_enable,
    input wire logic       indexer_enable,
    input wire logic       inputs_ready
);
    logic [15:0] slp_cnt_q;
    logic [8:0]  ocp_cnt_q;
    logic        asleep;
    // run lengths saturate so a long sleep never wraps back to awake
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sleep_in_low_active)
            slp_cnt_q <= 16'h0;
        else if (slp_cnt_q != 16'hffff)
            slp_cnt_q <= slp_cnt_q + 16'h1;
        if (!rst_n || !sleep_in_low_active || fet_current_limit == 8'h0)
            ocp_cnt_q <= 9'h0;
        else if (ocp_cnt_q != 9'h1ff)
            ocp_cnt_q <= ocp_cnt_q + 9'h1;
    end
    // margin covers the two sync flops and the output register
    assign asleep = int'(slp_cnt_q) > SLEEP_CYC + 6;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_woken;
        asleep ##1 sleep_in_low_active;
    endsequence
    // bound sized for the short wake count only
    sequence s_ready_late;
        !inputs_ready [*8] ##[1:60] inputs_ready;
    endsequence
    a_fault_pin_data: assert property (fault_out_low_active == 1'b0)
        else $error("fault pin data not low");
    a_uv_bridge_off: assert property (pump_rail_undervoltage [*6] |-> !bridge_enable)
        else $error("bridge on during pump rail low");
    a_live_fault_low: assert property ((pump_rail_undervoltage || supply_lockout) [*6]
        |-> fault_out_low_active_oe) else $error("fault released while live");
    a_lockout_all_off: assert property (supply_lockout [*6]
        |-> !bridge_enable && !pump_enable) else $error("drive on in lockout");
    a_thermal_off: assert property ((thermal_shutdown && sleep_in_low_active) [*8]
        |-> !bridge_enable && !pump_enable && fault_out_low_active_oe)
        else $error("thermal shutdown not applied");
    a_disable_mode: assert property ((sleep_in_low_active && !enable_pin_high
        && !enable_pin_float) [*6] |-> !bridge_enable) else $error("bridge on while disabled");
    a_sleep_all_off: assert property (asleep |-> !bridge_enable && !pump_enable
        && !regulator_enable && !indexer_enable) else $error("block awake in sleep");
    a_ocp_trip: assert property (ocp_cnt_q == 9'hd4
        |-> fault_out_low_active_oe && !bridge_enable) else $error("overcurrent not tripped");
    a_wake_wait: assert property (s_woken |-> s_ready_late)
        else $error("ready timing wrong after wake");
endmodule

bind motor_fault_ctrl motor_fault_ctrl_properties #(.SLEEP_CYC(SLEEP_CYC))
    i_motor_fault_ctrl_properties (.*);

// [dv/step_controller_model.sv]
// external controller: drives sleep and enable pins, pulls the fault wire up
// assumes the bench calls its tasks from one process, right after a clock edge
`timescale 1ns/10ps
module step_controller_model (
    input  wire logic ref_clk,
    input  wire logic fault_out_low_active,
    input  wire logic fault_out_low_active_oe,
    output logic      fault_line,
    output logic      sleep_in_low_active,
    output logic      enable_pin_high,
    output logic      enable_pin_float
);
    // pull-up on the open drain wire
    assign fault_line = fault_out_low_active_oe ? fault_out_low_active : 1'b1;
    initial begin
        sleep_in_low_active = 1'b1;
        enable_pin_high     = 1'b1;
        enable_pin_float    = 1'b0;
    end
    // enable as low, high or floating
    task automatic set_enable(input int lvl);
        @(posedge ref_clk);
        enable_pin_high  <= (lvl == 1);
        enable_pin_float <= (lvl == 2);
    endtask
    // sleep level, wake is waited out by the caller
    task automatic set_sleep(input logic lvl);
        @(posedge ref_clk);
        sleep_in_low_active <= lvl;
    endtask
    // sleep low for n cycles then high
    task automatic pulse(input int n);
        set_sleep(1'b0);
        repeat (n) @(posedge ref_clk);
        sleep_in_low_active <= 1'b1;
    endtask
endmodule

// [dv/motor_fault_ctrl_tb_top.sv]
// directed self-checking bench for the motor driver fault and mode block
// assumes the package, the design and the controller model compile first
`timescale 1ns/10ps
module motor_fault_ctrl_tb_top;
    import fault_pkg::*;
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
    logic        ref_clk, rst_n, supply_lockout, pump_rail_undervoltage, thermal_shutdown;
    logic        read, write, bridge_enable, pump_enable, regulator_enable, indexer_enable;
    logic        inputs_ready, fault_out_low_active, fault_out_low_active_oe, waitrequest;
    logic        sleep_in_low_active, enable_pin_high, enable_pin_float, fault_line;
    logic [7:0]  fet_current_limit;
    logic [1:0]  coil_below_threshold;
    logic [3:0]  address;
    logic [31:0] writedata, readdata, rd;
    int          fails, n_compared, cyc_n;
    motor_fault_ctrl #(.SLEEP_CYC(6000), .RETRY_CYC(50), .OL_CYC(50), .WAKE_CYCS(20))
        i_motor_fault_ctrl (.*);
    step_controller_model i_step_controller_model (.*);
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic look(input logic b, input logic p, input logic f);
        `CHK("bridge", b, bridge_enable)
        `CHK("pump", p, pump_enable)
        `CHK("fault", f, ~fault_line)
    endtask
    // request held until the rising edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        address <= a;
        writedata <= wd;
        read <= ~wr;
        write <= wr;
        @(posedge ref_clk iff (waitrequest === 1'b0));
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // each call lights other fets so every limit input is exercised
    task automatic ocp_hit(input logic [7:0] lim);
        fet_current_limit <= lim;
        cyc(230);
        fet_current_limit <= 8'h0;
        cyc(10);
    endtask
    task automatic t_rails();
        cyc(40);
        look(1, 1, 0);
        pump_rail_undervoltage <= 1'b1;
        cyc(8);
        look(0, 1, 1);
        pump_rail_undervoltage <= 1'b0;
        cyc(8);
        look(1, 1, 0);
        supply_lockout <= 1'b1;
        cyc(8);
        look(0, 0, 1);
        supply_lockout <= 1'b0;
        cyc(50);
        look(1, 1, 0);
    endtask
    task automatic t_ocp();
        ocp_hit(8'h81);
        look(0, 1, 1);
        cyc(80);
        look(1, 1, 0);
        i_step_controller_model.set_enable(2);
        ocp_hit(8'h42);
        cyc(100);
        look(0, 1, 1);
        i_step_controller_model.pulse(1500);
        cyc(10);
        look(0, 1, 1);
        i_step_controller_model.pulse(3000);
        cyc(10);
        look(1, 1, 0);
        `CHK("regulator", 1'b1, regulator_enable & indexer_enable & inputs_ready)
        ocp_hit(8'h24);
        i_step_controller_model.pulse(4500);
        cyc(10);
        `CHK("fault", 1'b1, fault_line)
        ocp_hit(8'h18);
        i_step_controller_model.set_enable(1);
        cyc(80);
        look(1, 1, 0);
    endtask
    task automatic t_thermal_load();
        thermal_shutdown <= 1'b1;
        cyc(10);
        look(0, 0, 1);
        `CHK("indexer", 1'b1, indexer_enable)
        thermal_shutdown <= 1'b0;
        cyc(12);
        look(1, 1, 0);
        i_step_controller_model.set_enable(2);
        thermal_shutdown <= 1'b1;
        cyc(10);
        thermal_shutdown <= 1'b0;
        cyc(20);
        look(0, 0, 1);
        i_step_controller_model.pulse(3000);
        cyc(12);
        look(1, 1, 0);
        i_step_controller_model.set_enable(1);
        coil_below_threshold <= 2'h2;
        cyc(70);
        look(1, 1, 1);
        coil_below_threshold <= 2'h0;
        cyc(8);
        look(1, 1, 0);
    endtask
    task automatic t_modes();
        i_step_controller_model.set_enable(0);
        cyc(8);
        look(0, 1, 0);
        `CHK("regulator", 1'b1, regulator_enable & indexer_enable)
        i_step_controller_model.set_enable(2);
        coil_below_threshold <= 2'h1;
        cyc(70);
        coil_below_threshold <= 2'h0;
        cyc(20);
        look(1, 1, 1);
        i_step_controller_model.set_sleep(0);
        cyc(6100);
        `CHK("awake", 4'h0, {bridge_enable, pump_enable, regulator_enable, indexer_enable})
        i_step_controller_model.set_sleep(1);
        cyc(8);
        `CHK("ready", 1'b0, inputs_ready)
        cyc(40);
        look(1, 1, 0);
        `CHK("ready", 1'b1, inputs_ready)
        i_step_controller_model.set_enable(1);
    endtask
    task automatic t_regs();
        pump_rail_undervoltage <= 1'b1;
        cyc(8);
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("status", 4'hd, {rd[ST_PUMP_RAIL_UNDERVOLTAGE], rd[ST_FAULT], rd[ST_BRIDGE], rd[ST_PUMP]})
        `CHK("mode", 2'(MODE_RUN), rd[ST_MODE+:2])
        pump_rail_undervoltage <= 1'b0;
        bus(1'b1, CTRL_OFS, 32'h5a5a5a5b);
        cyc(6);
        `CHK("bridge", 1'b0, bridge_enable)
        bus(1'b0, CTRL_OFS, 32'h0);
        `CHK("ctrl", 32'h1, rd)
        bus(1'b0, 4'hb, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        bus(1'b1, CTRL_OFS, 32'ha5a5a5a4);
        cyc(6);
        `CHK("bridge", 1'b1, bridge_enable)
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard, well above the roughly 20000 cycles the run needs
    always @(posedge ref_clk) begin
        cyc_n++;
        if (cyc_n == 60000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        {rst_n, supply_lockout, pump_rail_undervoltage, thermal_shutdown, read, write} = 6'h0;
        fet_current_limit = 8'h0;
        coil_below_threshold = 2'h0;
        address = 4'h0;
        writedata = 32'h0;
        cyc(6);
        rst_n <= 1'b1;
        t_rails();
        t_ocp();
        t_thermal_load();
        t_modes();
        t_regs();
        test_done();
    end
endmodule
